// file: rtl/aipc_pkg.sv
package aipc_pkg;
	// Data widths
	localparam int SMP_W = 20;
	localparam int ADDR_W = 8;
	localparam int PEAK_W = 10;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_GAIN = 8'h04;
	localparam logic [7:0] REG_PEAK = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	// Control register fields
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_SIL_L = 2;
	localparam int CTRL_SIL_R = 3;
	localparam int CTRL_SIL_M = 4;
	localparam int CTRL_HPF_EN = 5;
	localparam int CTRL_W = 6;
	localparam logic [5:0] CTRL_RST = 6'h20;
	// Gain register fields
	localparam int GAIN_L_LSB = 0;
	localparam int GAIN_R_LSB = 2;
	localparam int GAIN_W = 4;
	localparam logic [3:0] GAIN_RST = 4'h0;
	// Peak and status fields
	localparam int PEAK_L_LSB = 0;
	localparam int PEAK_R_LSB = 10;
	localparam int PEAK_M_LSB = 20;
	localparam int STAT_UNDER = 0;
	localparam int STAT_LVL_LSB = 8;
	// Input pair codes
	localparam logic [1:0] SEL_PAIR1 = 2'h0;
	localparam logic [1:0] SEL_PAIR2 = 2'h1;
	localparam logic [1:0] SEL_PAIR3 = 2'h2;
	localparam logic [1:0] SEL_DIFF = 2'h3;
	// DC blocker pole 1-2^-11: corner near 3.4 Hz at 44.1 kHz
	localparam int HPF_SHIFT = 11;
	localparam int ACC_W = SMP_W + HPF_SHIFT + 1;
	// Gain codes 0..3 as 0, 3, 6, 9 dB in unsigned Q3.12
	localparam int GAIN_FRAC = 12;
	localparam logic [14:0] GAIN_COEF [4] = '{15'h1000, 15'h169a,
		15'h1fed, 15'h2d18};
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Raw converter samples, one per analog pin
	typedef struct packed {
		logic signed [19:0] l1, r1, l2, r2, l3, r3, mono;
	} aipc_raw_t;
	// One output frame
	typedef struct packed {
		logic signed [19:0] left, right, mono;
	} aipc_frame_t;
endpackage : aipc_pkg

// file: rtl/aipc_top.sv
`timescale 1ns/1ps
// What this block does
// - Three stereo pairs, one mono 20-bit channels
// - Two-bit select picks one input pair
// - Select code 3 gives differential inputs
// - Left, right, mono silenced independently
// - Left and right two-bit gain, 3 dB steps
// - Gain applies at once on write
// - Track largest level since last read
// - Reading peak register clears it
// - High-pass after decimation removes DC
// - First order, 3.4 Hz at 44.1 kHz
// - Corner scales with sample rate
// - Capture data on its own port
// - Host writes settings over control bus

// Frame buffer between the sample path and the serial port
module aipc_fifo #(
	parameter int WIDTH = 60,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// Fill level
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_q, wp_d, rp_q, rp_d;
	logic push, pop;

	// Handshakes and honest full or empty
	assign level = wp_q - rp_q;
	assign in_ready = (level != (AW+1)'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data = mem[rp_q[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer next values
	always_comb begin
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
	end

	// Pointer registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end

	// Storage
	always_ff @(posedge aclk) begin
		if (push) begin
			mem[wp_q[AW-1:0]] <= in_data;
		end
	end
endmodule : aipc_fifo

module aipc_top #(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [aipc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [aipc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Decimated converter samples
	input wire aipc_pkg::aipc_raw_t raw_sample,
	input wire logic raw_valid,
	output logic raw_ready,
	// Capture serial port pins
	input wire logic cap_bit_clk,
	input wire logic cap_frame_clk,
	output logic cap_data,
	output logic cap_mono_data
);
	import aipc_pkg::*;

	// Saturate a wide signed value to one sample
	function automatic logic signed [SMP_W-1:0] sat(
		input logic signed [35:0] x);
		logic signed [35:0] hi, lo;
		hi = 36'sd524287;
		lo = -36'sd524288;
		if (x > hi) begin
			sat = hi[SMP_W-1:0];
		end else if (x < lo) begin
			sat = lo[SMP_W-1:0];
		end else begin
			sat = x[SMP_W-1:0];
		end
	endfunction : sat

	// Apply a gain code to a sample
	function automatic logic signed [SMP_W-1:0] gain(
		input logic signed [SMP_W-1:0] x, input logic [1:0] code);
		logic signed [35:0] p;
		p = 36'(x) * $signed({21'h0, GAIN_COEF[code]});
		gain = sat(p >>> GAIN_FRAC);
	endfunction : gain

	// Peak level of a sample, top bits of its magnitude
	function automatic logic [PEAK_W-1:0] mag(
		input logic signed [SMP_W-1:0] x);
		logic [SMP_W-1:0] a;
		a = x[SMP_W-1] ? SMP_W'(-x) : x;
		if (a[SMP_W-1]) begin
			a = {1'b0, {(SMP_W-1){1'b1}}};
		end
		mag = a[SMP_W-2 -: PEAK_W];
	endfunction : mag

	logic [CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [GAIN_W-1:0] gain_q, gain_d;
	logic [PEAK_W-1:0] peak_q [3], peak_d [3];
	logic under_q, under_d;
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic signed [ACC_W-1:0] acc_q [3], acc_d [3];
	logic wr_do, rd_do, peak_clr, push;
	logic [$clog2(FIFO_DEPTH):0] fifo_lvl;
	logic fifo_ready, fifo_valid, pop;
	// Frame clock fall, also read by the underrun flag
	logic frame_load_fall;
	aipc_frame_t frame_in, frame_out;
	logic signed [SMP_W-1:0] pre [3];

	// Bus handshakes
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign wr_do = aw_have_q && w_have_q && !bvalid_q;
	assign rd_do = s_axi_arvalid && s_axi_arready;
	assign peak_clr = rd_do && (s_axi_araddr == REG_PEAK);

	// Register file and bus next values
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q && !s_axi_bready;
		bresp_d = bresp_q;
		ctrl_d = ctrl_q;
		gain_d = gain_q;
		under_d = under_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (wr_do) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			unique case (awaddr_q)
				REG_CTRL: if (wstrb_q[0]) ctrl_d = wdata_q[CTRL_W-1:0];
				REG_GAIN: if (wstrb_q[0]) gain_d = wdata_q[GAIN_W-1:0];
				REG_STAT: begin
					if (wstrb_q[0] && wdata_q[STAT_UNDER]) under_d = 1'b0;
				end
				REG_PEAK: ;
				default: bresp_d = RESP_SLVERR;
			endcase
		end
		// Underrun set wins over clear
		if (pop == 1'b0 && frame_load_fall && !fifo_valid) under_d = 1'b1;
	end

	// Read answer next values
	always_comb begin
		rvalid_d = rvalid_q && !s_axi_rready;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (rd_do) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = '0;
			unique case (s_axi_araddr)
				REG_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
				REG_GAIN: rdata_d[GAIN_W-1:0] = gain_q;
				REG_PEAK: begin
					rdata_d[PEAK_L_LSB +: PEAK_W] = peak_q[0];
					rdata_d[PEAK_R_LSB +: PEAK_W] = peak_q[1];
					rdata_d[PEAK_M_LSB +: PEAK_W] = peak_q[2];
				end
				REG_STAT: begin
					rdata_d[STAT_UNDER] = under_q;
					rdata_d[STAT_LVL_LSB +: $bits(fifo_lvl)] = fifo_lvl;
				end
				default: rresp_d = RESP_SLVERR;
			endcase
		end
	end

	// Sample path: mux, gain, DC removal, silence, peak
	assign push = raw_valid && fifo_ready;
	// Back-pressure reaches the converter side
	assign raw_ready = fifo_ready;
	always_comb begin
		logic signed [SMP_W:0] dl, dr;
		logic signed [SMP_W-1:0] y [3];
		logic sil [3];
		dl = '0;
		dr = '0;
		y = '{default: '0};
		sil = '{default: 1'b0};
		// Pair select; code 3 is differential
		unique case (ctrl_q[CTRL_SEL_LSB +: 2])
			SEL_PAIR1: begin pre[0] = raw_sample.l1; pre[1] = raw_sample.r1; end
			SEL_PAIR2: begin pre[0] = raw_sample.l2; pre[1] = raw_sample.r2; end
			SEL_PAIR3: begin pre[0] = raw_sample.l3; pre[1] = raw_sample.r3; end
			SEL_DIFF: begin
				dl = (SMP_W+1)'(raw_sample.l3) - (SMP_W+1)'(raw_sample.l2);
				dr = (SMP_W+1)'(raw_sample.r1) - (SMP_W+1)'(raw_sample.r2);
				pre[0] = dl[SMP_W:1];
				pre[1] = dr[SMP_W:1];
			end
		endcase
		// Separate gains; code n is n x 3 dB
		pre[0] = gain(pre[0], gain_q[GAIN_L_LSB +: 2]);
		pre[1] = gain(pre[1], gain_q[GAIN_R_LSB +: 2]);
		pre[2] = raw_sample.mono;
		sil[0] = ctrl_q[CTRL_SIL_L];
		sil[1] = ctrl_q[CTRL_SIL_R];
		sil[2] = ctrl_q[CTRL_SIL_M];
		for (int i = 0; i < 3; i++) begin
			// DC removal; pole 1-2^-11 per sample
			y[i] = pre[i];
			acc_d[i] = acc_q[i];
			if (ctrl_q[CTRL_HPF_EN]) begin
				y[i] = sat(36'(pre[i]) - 36'(acc_q[i] >>> HPF_SHIFT));
			end
			// Updates once per sample, so corner tracks rate
			if (push && ctrl_q[CTRL_HPF_EN]) begin
				acc_d[i] = acc_q[i] + ACC_W'(y[i]);
			end
			if (sil[i]) y[i] = '0;
			// Hold the largest level; restart after read
			peak_d[i] = peak_clr ? '0 : peak_q[i];
			if (push && mag(y[i]) > peak_d[i]) peak_d[i] = mag(y[i]);
		end
		frame_in.left = y[0];
		frame_in.right = y[1];
		frame_in.mono = y[2];
	end

	// Control, path and bus registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RST;
			gain_q <= GAIN_RST;
			under_q <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
			for (int i = 0; i < 3; i++) begin
				peak_q[i] <= '0;
				acc_q[i] <= '0;
			end
		end else begin
			ctrl_q <= ctrl_d;
			gain_q <= gain_d;
			under_q <= under_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			for (int i = 0; i < 3; i++) begin
				peak_q[i] <= peak_d[i];
				acc_q[i] <= acc_d[i];
			end
		end
	end

	aipc_fifo #(
		.WIDTH($bits(aipc_frame_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(frame_in),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(frame_out),
		.level(fifo_lvl)
	);

	// Pin synchronisers: three stages, change accepted when 2 and 3 agree
	logic [2:0] bclk_s_q, fclk_s_q;
	logic bclk_q, fclk_q, bclk_d, fclk_d;
	logic frame_load_rise, bit_fall;
	logic [SMP_W-1:0] sh_q, sh_d, msh_q, msh_d, right_q, right_d;
	assign bclk_d = (bclk_s_q[1] == bclk_s_q[2]) ? bclk_s_q[2] : bclk_q;
	assign fclk_d = (fclk_s_q[1] == fclk_s_q[2]) ? fclk_s_q[2] : fclk_q;
	assign frame_load_fall = fclk_q && !fclk_d;
	assign frame_load_rise = !fclk_q && fclk_d;
	assign bit_fall = bclk_q && !bclk_d;
	// Each frame start takes one buffered frame
	assign pop = frame_load_fall && fifo_valid;

	// Capture port shifter, MSB first, left while frame clock low
	always_comb begin
		sh_d = sh_q;
		msh_d = msh_q;
		right_d = right_q;
		if (frame_load_fall) begin
			sh_d = fifo_valid ? frame_out.left : '0;
			msh_d = fifo_valid ? frame_out.mono : '0;
			right_d = fifo_valid ? frame_out.right : '0;
		end else if (frame_load_rise) begin
			sh_d = right_q;
		end else if (bit_fall) begin
			sh_d = {sh_q[SMP_W-2:0], 1'b0};
			msh_d = {msh_q[SMP_W-2:0], 1'b0};
		end
	end

	// Synchroniser and shifter registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bclk_s_q <= '0;
			fclk_s_q <= '0;
			bclk_q <= 1'b0;
			fclk_q <= 1'b0;
			sh_q <= '0;
			msh_q <= '0;
			right_q <= '0;
		end else begin
			bclk_s_q <= {bclk_s_q[1:0], cap_bit_clk};
			fclk_s_q <= {fclk_s_q[1:0], cap_frame_clk};
			bclk_q <= bclk_d;
			fclk_q <= fclk_d;
			sh_q <= sh_d;
			msh_q <= msh_d;
			right_q <= right_d;
		end
	end

	// Serial data from the shifters
	assign cap_data = sh_q[SMP_W-1];
	assign cap_mono_data = msh_q[SMP_W-1];
endmodule : aipc_top

// file: dv/aipc_checker.sv
`timescale 1ns/1ps
// Protocol watcher on the top ports
module aipc_checker #(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write channels
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels
	input wire logic [aipc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Capture port
	input wire logic cap_bit_clk,
	input wire logic cap_frame_clk,
	input wire logic cap_data,
	input wire logic cap_mono_data
);
	import aipc_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Bus handshakes and answers
	AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("no write response two cycles after address and data");
	AST_B_STAND: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	AST_R_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_STAND: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data changed before rready");
	AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > REG_STAT |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	// Serial lines hold while the port clocks rest
	AST_CAP_QUIET: assert property (($stable(cap_bit_clk) && $stable(cap_frame_clk)) [*8] |-> $stable(cap_data) && $stable(cap_mono_data))
		else $error("capture data moved without clock edge");
endmodule : aipc_checker

bind aipc_top aipc_checker #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (.*);

// file: dv/aipc_cap_rx.sv
`timescale 1ns/1ps
// Receiver at the capture port, makes bit and frame clocks
module aipc_cap_rx (
	// Clock
	input wire logic aclk,
	// Serial lines from the block
	input wire logic sd,
	input wire logic sm,
	// Clocks to the block, idle high between frames
	output logic bclk,
	output logic fclk
);
	import aipc_pkg::*;
	aipc_frame_t frm;
	// Idle levels
	initial begin
		bclk = 1'b1;
		fclk = 1'b1;
		frm = '0;
	end
	// one frame on the capture port
	task automatic grab();
		int i;
		fclk <= 1'b0;
		for (i = 0; i < 40; i++) begin
			if (i == 20) fclk <= 1'b1;
			repeat (8) @(posedge aclk);
			if (i < 20) begin
				frm.left[19-i] = sd;
				frm.mono[19-i] = sm;
			end else begin
				frm.right[39-i] = sd;
			end
			if (i != 19 && i != 39) bclk <= 1'b0;
			repeat (8) @(posedge aclk);
			bclk <= 1'b1;
		end
	endtask : grab
endmodule : aipc_cap_rx

// file: dv/adc_input_path_control_bench.sv
`timescale 1ns/1ps
// Register and sample path tests
module adc_input_path_control_bench;
	import aipc_pkg::*;
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, raw_valid, raw_ready;
	logic cap_bit_clk, cap_frame_clk, cap_data, cap_mono_data;
	aipc_raw_t raw_sample, s;
	logic signed [19:0] el [4], er [4];
	int fail_count, cmp_count, n;

	aipc_top #(.FIFO_DEPTH(8)) i_dut (.*);
	aipc_cap_rx i_rx (.aclk(aclk), .sd(cap_data), .sm(cap_mono_data),
		.bclk(cap_bit_clk), .fclk(cap_frame_clk));

	// Clock
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(logic [7:0] a, logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic rc(logic [7:0] a, logic [31:0] e, string nm);
		rd(a);
		chk(nm, e, rv);
	endtask : rc

	task automatic push(aipc_raw_t v);
		raw_sample <= v;
		raw_valid <= 1'b1;
		do @(posedge aclk);
		while (raw_ready !== 1'b1);
		raw_valid <= 1'b0;
		@(posedge aclk);
	endtask : push

	task automatic final_report();
		if (fail_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// Watchdog
	initial begin
		repeat (40000) @(posedge aclk);
		fail_count++;
		final_report();
	end

	// Main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, raw_valid} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		raw_sample = '0;
		s = '0;
		el = '{20'h00011, 20'h00021, 20'h00031, 20'h00008};
		er = '{20'h00012, 20'h00022, 20'h00032, 20'hffff8};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(REG_CTRL, 32'h20, "ctrl reset");
		rc(REG_GAIN, 32'h0, "gain reset");
		rd(8'h10);
		chk("unmapped read", RESP_SLVERR, rsp);
		wr(8'h10, 32'hff);
		chk("unmapped write", RESP_SLVERR, rsp);
		// Gain codes, silenced around each change
		for (n = 0; n < 4; n++) begin
			wr(REG_CTRL, 32'h1c);
			wr(REG_GAIN, n | ((3 - n) << 2));
			wr(REG_CTRL, 32'h0);
			s.l1 = 20'h01000;
			s.r1 = 20'h01000;
			s.mono = 20'h01000;
			push(s);
			i_rx.grab();
			chk("left gain", GAIN_COEF[n], i_rx.frm.left);
			chk("right gain", GAIN_COEF[3-n], i_rx.frm.right);
			chk("mono", 32'h01000, i_rx.frm.mono);
		end
		// Input pair select and differential
		wr(REG_GAIN, 32'h0);
		s = '{20'h11, 20'h12, 20'h21, 20'h22, 20'h31, 20'h32, 20'h5};
		for (n = 0; n < 4; n++) begin
			wr(REG_CTRL, n);
			push(s);
			i_rx.grab();
			chk("left sel", el[n], i_rx.frm.left);
			chk("right sel", er[n], i_rx.frm.right);
		end
		// Left and mono silenced, right live
		wr(REG_CTRL, 32'h14);
		push(s);
		i_rx.grab();
		chk("left silence", 32'h0, i_rx.frm.left);
		chk("right live", 32'h12, i_rx.frm.right);
		chk("mono silence", 32'h0, i_rx.frm.mono);
		// Peak holds the largest level, cleared by reading
		wr(REG_CTRL, 32'h0);
		rd(REG_PEAK);
		s = '{20'h01000, 20'h02000, 20'h0, 20'h0, 20'h0, 20'h0, 20'h00400};
		push(s);
		s = '{20'h00200, 20'h0, 20'h0, 20'h0, 20'h0, 20'h0, 20'h0};
		push(s);
		rc(REG_PEAK, 32'h00204008, "peak");
		rc(REG_PEAK, 32'h0, "peak cleared");
		// Fill the buffer until it refuses, then drain
		wr(REG_STAT, 32'h1);
		repeat (6) push(s);
		chk("raw_ready full", 32'h0, raw_ready);
		rc(REG_STAT, 32'h800, "stat full");
		i_rx.grab();
		chk("first out", 32'h01000, i_rx.frm.left);
		repeat (7) i_rx.grab();
		i_rx.grab();
		chk("underrun data", 32'h0, i_rx.frm.left);
		rc(REG_STAT, 32'h1, "stat underrun");
		wr(REG_STAT, 32'h1);
		rc(REG_STAT, 32'h0, "stat cleared");
		// DC removal: step input, second sample already pulled down
		wr(REG_CTRL, 32'h20);
		s = '{20'h01000, 20'h0, 20'h0, 20'h0, 20'h0, 20'h0, 20'h0};
		push(s);
		i_rx.grab();
		chk("hpf first", 32'h01000, i_rx.frm.left);
		push(s);
		i_rx.grab();
		chk("hpf second", 32'h00ffe, i_rx.frm.left);
		final_report();
	end
endmodule : adc_input_path_control_bench
